// ---- pkg/adcc_pkg.sv ----
// package for the converter control block: register map, field positions, reset values, carriers
// assumes a 32-bit apb slave with one register per aligned word
`default_nettype none
package adcc_pkg;
    localparam logic [11:0] ADDR_RESULT_LOW = 12'h000;
    localparam logic [11:0] ADDR_RESULT_HIGH = 12'h004;
    localparam logic [11:0] ADDR_CONTROL_0 = 12'h008;
    localparam logic [11:0] ADDR_CONTROL_1 = 12'h00c;
    localparam logic [11:0] ADDR_REFERENCE = 12'h010;
    localparam logic [11:0] ADDR_PIN_ENABLE = 12'h014;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h018;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h01c;

    localparam int C0_START = 7;
    localparam int C0_BUSY = 6;
    localparam int C0_ENABLE = 5;
    localparam int C0_JUSTIFY = 4;
    localparam int C0_CHAN_LSB = 0;
    localparam int C1_SRC_LSB = 5;
    localparam int C1_DIV_LSB = 0;
    localparam int IRQ_DONE = 0;

    localparam logic [7:0] C0_WRITE_MASK = 8'hb7;
    localparam logic [7:0] C1_WRITE_MASK = 8'he7;
    localparam logic [7:0] RESET_CONTROL_0 = 8'h00;
    localparam logic [7:0] RESET_CONTROL_1 = 8'h00;
    localparam logic [7:0] RESET_REFERENCE = 8'h00;
    localparam logic [7:0] RESET_PIN_ENABLE = 8'hff;
    localparam logic [7:0] RESET_IRQ = 8'h00;

    localparam logic [2:0] SRC_EXT_A = 3'h0;
    localparam logic [2:0] SRC_EXT_B = 3'h4;

    typedef enum logic [2:0] {
        ADCC_IDLE = 3'b001,
        ADCC_ARMED = 3'b010,
        ADCC_CONVERT = 3'b100
    } adcc_state_e;

    typedef struct packed {
        logic [7:0] ext_select;
        logic [5:0] int_select;
        logic core_enable;
        logic core_start;
        logic conv_clk_en;
    } adcc_analog_s;

    typedef struct packed {
        adcc_state_e state;
        logic [7:0] conv_control_0;
        logic [7:0] conv_control_1;
        logic [7:0] conv_reference_control;
        logic [7:0] analog_pin_enable;
        logic [11:0] result;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [6:0] div_count;
        logic [31:0] prdata;
        logic pready;
        logic irq;
        adcc_analog_s analog;
        logic [7:0] pullup_disable;
    } adcc_state_s;
endpackage
`default_nettype wire

// ---- design/adcc_top.sv ----
// converter control and result registers behind an apb slave
// assumes the converter core pulses core_done with a 12-bit result, synchronous to clk
//
// Local design decisions: the APB slave port and the placing of the registers.
`default_nettype none
module adcc_top
    import adcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_done,
    input wire logic [11:0] core_result,
    output adcc_analog_s analog,
    output logic [7:0] pin_analog_enables,
    output logic [7:0] pullup_disable,
    output logic [7:0] conv_reference_control,
    output logic irq
);
    adcc_state_s r;
    adcc_state_s next_r;
    logic wr;
    logic rd;
    logic ext_src;
    logic enable;
    logic [6:0] div_limit;
    logic [7:0] res_low;
    logic [7:0] res_high;
    logic [2:0] src;

    always_comb begin
        // writes land at the access edge where ready is seen, never in setup
        wr = psel && penable && pwrite && r.pready;
        rd = psel && !penable && !pwrite;
        enable = r.conv_control_0[C0_ENABLE];
        src = r.conv_control_1[C1_SRC_LSB +: 3];
        ext_src = (src == SRC_EXT_A) || (src == SRC_EXT_B);
        div_limit = 7'((8'h01 << r.conv_control_1[C1_DIV_LSB +: 3]) - 8'h01);
        if (r.conv_control_0[C0_JUSTIFY]) begin
            res_high = {4'h0, r.result[11:8]};
            res_low = r.result[7:0];
        end else begin
            res_high = r.result[11:4];
            res_low = {r.result[3:0], 4'h0};
        end
    end

    always_comb begin
        next_r = r;
        // apb answers one cycle after setup: data is ready in the access phase
        next_r.pready = psel && !penable;
        if (wr) begin
            unique case (paddr)
                ADDR_CONTROL_0: begin
                    // busy is hardware owned; only writable bits taken
                    next_r.conv_control_0 = (pwdata[7:0] & C0_WRITE_MASK) |
                        (r.conv_control_0 & ~C0_WRITE_MASK);
                end
                ADDR_CONTROL_1: next_r.conv_control_1 = pwdata[7:0] & C1_WRITE_MASK;
                ADDR_REFERENCE: next_r.conv_reference_control = pwdata[7:0];
                ADDR_PIN_ENABLE: next_r.analog_pin_enable = pwdata[7:0];
                ADDR_IRQ_STATUS: next_r.irq_status = r.irq_status & ~pwdata[7:0];
                ADDR_IRQ_MASK: next_r.irq_mask = pwdata[7:0];
                default: ; // result bytes and unmapped writes are ignored
            endcase
        end
        if (rd) begin
            next_r.prdata = 32'h0;
            case (paddr)
                ADDR_RESULT_LOW: next_r.prdata[7:0] = res_low;
                ADDR_RESULT_HIGH: next_r.prdata[7:0] = res_high;
                ADDR_CONTROL_0: next_r.prdata[7:0] = r.conv_control_0;
                ADDR_CONTROL_1: next_r.prdata[7:0] = r.conv_control_1;
                ADDR_REFERENCE: next_r.prdata[7:0] = r.conv_reference_control;
                ADDR_PIN_ENABLE: next_r.prdata[7:0] = r.analog_pin_enable;
                ADDR_IRQ_STATUS: next_r.prdata[7:0] = r.irq_status;
                ADDR_IRQ_MASK: next_r.prdata[7:0] = r.irq_mask;
                default: next_r.prdata = 32'h0;
            endcase
        end

        // conversion clock enable, free-running divider
        next_r.analog.conv_clk_en = 1'b0;
        if (!enable || r.div_count >= div_limit) begin
            next_r.div_count = 7'h00;
            next_r.analog.conv_clk_en = enable;
        end else begin
            next_r.div_count = r.div_count + 7'h01;
        end

        next_r.analog.core_start = 1'b0;
        case (r.state)
            ADCC_IDLE: begin
                if (enable && r.conv_control_0[C0_START]) begin
                    next_r.state = ADCC_ARMED;
                end
            end
            ADCC_ARMED: begin
                if (!enable) begin
                    next_r.state = ADCC_IDLE;
                end else if (!r.conv_control_0[C0_START]) begin
                    // only the falling half of the pulse launches the core
                    next_r.state = ADCC_CONVERT;
                    next_r.analog.core_start = 1'b1;
                    next_r.conv_control_0[C0_BUSY] = 1'b1;
                end
            end
            ADCC_CONVERT: begin
                if (!enable) begin
                    // power-down aborts; result stays untouched
                    next_r.state = ADCC_IDLE;
                    next_r.conv_control_0[C0_BUSY] = 1'b0;
                end else if (core_done) begin
                    next_r.state = ADCC_IDLE;
                    next_r.result = core_result;
                    next_r.conv_control_0[C0_BUSY] = 1'b0;
                    next_r.irq_status[IRQ_DONE] = 1'b1; // set wins over clear
                end
            end
            default: next_r.state = ADCC_IDLE;
        endcase

        next_r.analog.core_enable = enable;
        next_r.analog.ext_select = 8'h00;
        next_r.analog.int_select = 6'h00;
        if (enable) begin
            if (ext_src) begin
                next_r.analog.ext_select = 8'h01 << r.conv_control_0[C0_CHAN_LSB +: 3];
            end else begin
                // one-hot: 001..011 -> bits 0..2, 101..111 -> bits 3..5
                next_r.analog.int_select = 6'h01 << (3'(src[2] ? 3'(src[1:0]) + 3'h2 : 3'(src[1:0]) - 3'h1));
            end
        end
        next_r.pullup_disable = r.analog_pin_enable;
        next_r.irq = |(next_r.irq_status & r.irq_mask);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '{state: ADCC_IDLE, conv_control_0: RESET_CONTROL_0, conv_control_1: RESET_CONTROL_1,
                conv_reference_control: RESET_REFERENCE, analog_pin_enable: RESET_PIN_ENABLE,
                result: 12'h000, irq_status: RESET_IRQ, irq_mask: RESET_IRQ, div_count: 7'h00,
                prdata: 32'h0, pready: 1'b0, irq: 1'b0, analog: '0, pullup_disable: RESET_PIN_ENABLE};
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        prdata = r.prdata;
        pready = r.pready;
        pslverr = 1'b0;
        analog = r.analog;
        pin_analog_enables = r.analog_pin_enable;
        pullup_disable = r.pullup_disable;
        conv_reference_control = r.conv_reference_control;
        irq = r.irq;
    end
endmodule
`default_nettype wire

// ---- tb/adcc_core_model.sv ----
// partner model of the converter core
// assumes core_start and conv_clk_en come from the control block on clk
`default_nettype none
module adcc_core_model
    import adcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire adcc_analog_s analog,
    input wire logic [11:0] result_in,
    output logic core_done,
    output logic [11:0] core_result
);
    logic run;
    logic [2:0] cnt;
    // eight converter clock enables per conversion, so slow divider codes give slow answers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run <= 1'b0;
            cnt <= 3'h0;
            core_done <= 1'b0;
            core_result <= 12'h000;
        end else begin
            core_done <= 1'b0;
            core_result <= ~core_result; // result only valid with the done pulse
            if (analog.core_start) begin
                run <= 1'b1;
                cnt <= 3'h0;
            end else if (run && analog.conv_clk_en) begin
                cnt <= cnt + 3'h1;
                run <= cnt != 3'h7;
                core_done <= cnt == 3'h7;
                if (cnt == 3'h7) core_result <= result_in;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/adcc_checker.sv ----
// assertions on the control block ports
// assumes binding to adcc_top
`default_nettype none
module adcc_checker
    import adcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire adcc_analog_s analog,
    input wire logic [7:0] pin_analog_enables,
    input wire logic [7:0] pullup_disable,
    input wire logic irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_read_clean: assert property (psel && !penable |=> pready && prdata[31:8] == 24'h0) else $error("bad answer");
    a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
    a_ready_once: assert property (pready |=> !pready) else $error("long ready");
    a_ext_off: assert property (|analog.int_select |-> analog.ext_select == 8'h00) else $error("both paths");
    a_one_route: assert property ($onehot0({analog.ext_select, analog.int_select})) else $error("two inputs");
    a_off_idle: assert property (!analog.core_enable |-> !analog.core_start && !analog.conv_clk_en
        && analog.ext_select == 8'h00) else $error("active while off");
    a_start_once: assert property (analog.core_start |=> !analog.core_start) else $error("long start");
    a_pullup_lag: assert property (pullup_disable == $past(pin_analog_enables)) else $error("pullup");
    c_start: cover property (analog.core_start);
    c_irq: cover property ($rose(irq));
    c_internal: cover property (|analog.int_select);
endmodule
bind adcc_top adcc_checker chk_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .analog(analog), .pin_analog_enables(pin_analog_enables), .pullup_disable(pullup_disable),
    .irq(irq));
`default_nettype wire

// ---- tb/test_adc_control_registers.sv ----
// self-checking bench for the converter control block
// assumes the core model answers every start
`default_nettype none
module test_adc_control_registers import adcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, irq, core_done;
    logic [11:0] paddr = 12'h000, core_result, res = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h7448;
    logic [7:0] pae, pud, refc;
    adcc_analog_s analog;
    int error_cnt = 0, tests_run = 0, gap = 0, last_gap = 0;
    initial forever #5 clk = ~clk;
    // spacing of converter clock enables, in system clocks
    always @(posedge clk) begin
        if (analog.conv_clk_en) begin
            last_gap <= gap + 1;
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
    end
    adcc_top dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_done(core_done),
        .core_result(core_result), .analog(analog), .pin_analog_enables(pae), .pullup_disable(pud),
        .conv_reference_control(refc), .irq(irq));
    adcc_core_model model_u (.clk(clk), .nrst(nrst), .analog(analog), .result_in(res), .core_done(core_done),
        .core_result(core_result));
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // entered just after an edge; leaves one idle cycle so psel never toggles twice in a step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({pready, pslverr}, 2'b10);
        if (n == 20) begin
            error_cnt++;
            finish_test();
        end
        @(posedge clk);
    endtask
    function automatic void rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction
    function automatic logic [7:0] fmt(input logic [11:0] r, input logic j, hi);
        logic [15:0] v;
        v = j ? {4'h0, r} : {r, 4'h0};
        return hi ? v[15:8] : v[7:0];
    endfunction
    function automatic logic [7:0] ext_exp(input logic [2:0] s, c);
        return (s[1:0] == 2'b00) ? 8'h01 << c : 8'h00;
    endfunction
    function automatic logic [5:0] int_exp(input logic [2:0] s);
        return (s[1:0] == 2'b00) ? 6'h00 : 6'h01 << (s - (s[2] ? 3'h2 : 3'h1));
    endfunction
    initial begin
        logic [2:0] ch;
        logic j, busy;
        int n;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        xfer(0, ADDR_PIN_ENABLE, 0);
        chk(rd, 32'hff);
        xfer(0, 12'h020, 0);
        chk(rd, 32'h0);
        xfer(1, ADDR_CONTROL_1, 32'hff);
        xfer(0, ADDR_CONTROL_1, 0);
        chk(rd, 32'he7);
        xfer(1, ADDR_CONTROL_0, 32'h5f);
        xfer(0, ADDR_CONTROL_0, 0);
        chk(rd, 32'h17);
        // every source and divider code once; slow codes give long conversions
        for (int i = 0; i < 8; i++) begin
            rnd();
            res <= seed[11:0];
            ch = seed[14:12];
            j = seed[15];
            xfer(1, ADDR_PIN_ENABLE, {24'h0, seed[23:16]});
            xfer(1, ADDR_REFERENCE, {24'h0, seed[31:24]});
            xfer(1, ADDR_IRQ_MASK, {31'h0, i[0]});
            xfer(1, ADDR_CONTROL_1, {24'h0, i[2:0], 2'b00, i[2:0]});
            xfer(1, ADDR_CONTROL_0, {24'h0, 3'b101, j, 1'b0, ch});
            xfer(1, ADDR_CONTROL_0, {24'h0, 3'b001, j, 1'b0, ch});
            chk(analog.ext_select, ext_exp(i[2:0], ch));
            chk(analog.int_select, int_exp(i[2:0]));
            busy = 1'b0;
            n = 0;
            do begin
                xfer(0, ADDR_CONTROL_0, 0);
                busy |= rd[C0_BUSY];
                n++;
            end while (rd[C0_BUSY] !== 1'b0 && n < 600);
            chk({busy, rd[7:0]}, {1'b1, 3'b001, j, 1'b0, ch});
            if (n == 600) begin
                error_cnt++;
                finish_test();
            end
            chk(last_gap, 32'h1 << i);
            chk(irq, i[0]);
            chk({pae, pud, refc}, {seed[23:16], seed[23:16], seed[31:24]});
            xfer(1, ADDR_IRQ_STATUS, 32'h1);
            xfer(1, ADDR_RESULT_LOW, 32'hff);
            xfer(0, ADDR_RESULT_LOW, 0);
            chk(rd, fmt(res, j, 1'b0));
            xfer(0, ADDR_RESULT_HIGH, 0);
            chk({irq, rd[7:0]}, {1'b0, fmt(res, j, 1'b1)});
        end
        res <= ~res;
        xfer(1, ADDR_CONTROL_0, {24'h0, 3'b100, j, 4'h0});
        xfer(1, ADDR_CONTROL_0, {24'h0, 3'b000, j, 4'h0});
        xfer(0, ADDR_CONTROL_0, 0);
        chk({analog, rd[7:0]}, {17'h0, 3'b000, j, 4'h0});
        xfer(0, ADDR_RESULT_HIGH, 0);
        chk(rd, fmt(~res, j, 1'b1));
        finish_test();
    end
endmodule
`default_nettype wire
